// >>> hdl/pcg_top.sv
// Contract
// - Gate bit one supplies the unit clock
// - Gate bit zero stops and disables unit
// - Access to gated unit gives bus fault
// - All gate bits read zero after reset
// - Run, sleep, deep registers per mode
// - Sleep registers only with automatic gating
// - Run gate two at offset 0x108
// - Run two: bit16 usb, bit13 dma
// - Run two: bits 4..0 ports E..A
// - Deep one: bits 12, 4, 0
// - Sleep gate two at 0x118, same layout
// - Deep gate two at offset 0x128
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [1:0]  power_mode,
  input  wire logic [2:0]  run_group_one_gate,
  input  wire logic [2:0]  sleep_group_one_gate,
  input  wire logic        unit_access_valid,
  input  wire logic [3:0]  unit_access_sel,
  output logic             unit_access_fault,
  output logic [9:0]       unit_enable,
  output logic [9:0]       unit_clk,
  output logic             irq
);
  // Gate registers and configuration
  logic [31:0] run_two_q;     // Run-mode gate, group two
  logic [31:0] sleep_two_q;   // Sleep-mode gate, group two
  logic [31:0] deep_two_q;    // Deep-sleep gate, group two
  logic [31:0] deep_one_q;    // Deep-sleep gate, group one
  logic [31:0] run_cfg_q;     // Holds the automatic gating select
  logic [9:0]  irq_stat_q;    // Sticky fault flags per unit
  logic [9:0]  irq_stat_d;
  logic [9:0]  irq_mask_q;    // Interrupt mask per unit
  logic [9:0]  gate_d;        // Enables chosen for the current mode
  logic [9:0]  enable_q;      // Registered enables into the gate cells
  logic [9:0]  fault_set;     // One-hot fault event this cycle
  logic        fault_q;
  // Write channel holding state
  logic        aw_hold_q;
  logic [11:0] awaddr_q;
  logic        w_hold_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        do_write;      // Both halves present, response free
  // Read channel state
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        ar_take;       // Read address accepted this edge
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        auto_gate;

  // Merge byte lanes into a register, reserved bits forced low
  function automatic logic [31:0] apply_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res & mask;
  endfunction

  // unit field map
  // Per-unit enables from a group-two word and three group-one bits
  function automatic logic [9:0] unit_map(
    input logic [31:0] two,
    input logic [2:0]  one
  );
    return {one, two[USB_BIT], two[DMA_BIT],
            two[PORT_E_BIT:PORT_A_BIT]};
  endfunction

  // Group-one bits pulled from the deep-sleep group-one register
  function automatic logic [2:0] one_bits(input logic [31:0] w);
    return {w[TWO_WIRE_BIT], w[SYNC_SERIAL_BIT], w[ASYNC_SERIAL_BIT]};
  endfunction

  assign auto_gate = run_cfg_q[AUTO_GATE_BIT];

  // Channel readies: one write and one read in flight
  assign awready  = !aw_hold_q;
  assign wready   = !w_hold_q;
  assign arready  = !rvalid_q;
  assign ar_take  = arvalid && !rvalid_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;

  // Write address capture, address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (awvalid && !aw_hold_q) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= awaddr[11:0];
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (wvalid && !w_hold_q) begin
      w_hold_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  // Write response, error for an unmapped offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      case (awaddr_q)
        RUN_TWO_OFF, SLEEP_TWO_OFF, DEEP_TWO_OFF, DEEP_ONE_OFF,
        RUN_CFG_OFF, IRQ_STAT_OFF, IRQ_MASK_OFF: bresp_q <= RESP_OKAY;
        default: bresp_q <= RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Gate and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_two_q   <= GATE_RESET;
      sleep_two_q <= GATE_RESET;
      deep_two_q  <= GATE_RESET;
      deep_one_q  <= GATE_RESET;
      run_cfg_q   <= CFG_RESET;
      irq_mask_q  <= 10'h000;
    end else if (do_write) begin
      case (awaddr_q)
        RUN_TWO_OFF: run_two_q <=
          apply_strb(run_two_q, wdata_q, wstrb_q, GATE_TWO_MASK);
        SLEEP_TWO_OFF: sleep_two_q <=
          apply_strb(sleep_two_q, wdata_q, wstrb_q, GATE_TWO_MASK);
        DEEP_TWO_OFF: deep_two_q <=
          apply_strb(deep_two_q, wdata_q, wstrb_q, GATE_TWO_MASK);
        DEEP_ONE_OFF: deep_one_q <=
          apply_strb(deep_one_q, wdata_q, wstrb_q, GATE_ONE_MASK);
        RUN_CFG_OFF: run_cfg_q <=
          apply_strb(run_cfg_q, wdata_q, wstrb_q, RUN_CFG_MASK);
        IRQ_MASK_OFF: irq_mask_q <= 10'(
          apply_strb({22'h000000, irq_mask_q}, wdata_q, wstrb_q,
                     IRQ_MASK_MASK));
        // Status is read-to-clear, writes are ignored
        default: begin
        end
      endcase
    end
  end

  // Read data mux, reserved bits already stored as zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case (araddr[11:0])
      RUN_TWO_OFF:   rd_word = run_two_q;
      SLEEP_TWO_OFF: rd_word = sleep_two_q;
      DEEP_TWO_OFF:  rd_word = deep_two_q;
      DEEP_ONE_OFF:  rd_word = deep_one_q;
      RUN_CFG_OFF:   rd_word = run_cfg_q;
      IRQ_STAT_OFF:  rd_word = {22'h000000, irq_stat_q};
      IRQ_MASK_OFF:  rd_word = {22'h000000, irq_mask_q};
      default:       rd_hit  = 1'b0;
    endcase
  end

  // Read response register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Mode selection of the active gate register
  always_comb begin
    case (power_mode)
      MODE_SLEEP: gate_d = auto_gate
        ? unit_map(sleep_two_q, sleep_group_one_gate)
        : unit_map(run_two_q, run_group_one_gate);
      MODE_DEEP: gate_d = auto_gate
        ? unit_map(deep_two_q, one_bits(deep_one_q))
        : unit_map(run_two_q, run_group_one_gate);
      default: gate_d = unit_map(run_two_q, run_group_one_gate);
    endcase
  end

  // Registered enables, so a gate cell never sees a decode glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 10'h000;
    end else begin
      enable_q <= gate_d;
    end
  end

  assign unit_enable = enable_q;
  for (genvar u = 0; u < UNIT_COUNT; u++) begin : g_gate
    pcg_clock_gate u_gate (
      .clk_in  (aclk),
      .enable  (enable_q[u]),
      .clk_out (unit_clk[u])
    );
  end

  always_comb begin
    fault_set = 10'h000;
    if (unit_access_valid && unit_access_sel < UNIT_LIMIT &&
        !enable_q[unit_access_sel]) begin
      fault_set = 10'h001 << unit_access_sel;
    end
  end

  // Fault answer one cycle after the access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= |fault_set;
    end
  end
  assign unit_access_fault = fault_q;

  // Sticky status, a new fault wins over the read clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (ar_take && araddr[11:0] == IRQ_STAT_OFF) begin
      irq_stat_d = 10'h000;
    end
    irq_stat_d = irq_stat_d | fault_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 10'h000;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Level interrupt while any unmasked flag stands
  assign irq = |(irq_stat_q & irq_mask_q);

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence run_steady_s;
    power_mode == MODE_RUN ##1 power_mode == MODE_RUN &&
      $stable(run_two_q) && $stable(run_group_one_gate);
  endsequence

  sequence sleep_manual_s;
    power_mode == MODE_SLEEP && !auto_gate ##1
      power_mode == MODE_SLEEP && !auto_gate &&
      $stable(run_two_q) && $stable(run_group_one_gate);
  endsequence

  sequence full_write_s(logic [11:0] off);
    do_write && awaddr_q == off && wstrb_q == 4'hf;
  endsequence

  gates_reset_zero_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> run_two_q == 32'h0 && deep_one_q == 32'h0 &&
      unit_enable == 10'h000)
    else $error("gate bits not zero after reset");

  run_mode_apply_a: assert property (
    run_steady_s |-> unit_enable ==
      unit_map(run_two_q, run_group_one_gate))
    else $error("run register not applied in run mode");

  sleep_no_auto_a: assert property (
    sleep_manual_s |-> unit_enable ==
      unit_map(run_two_q, run_group_one_gate))
    else $error("sleep register used without automatic gating");

  gated_access_fault_a: assert property (
    unit_access_valid && unit_access_sel < UNIT_LIMIT &&
    !unit_enable[unit_access_sel] |=> unit_access_fault ##0
    irq_stat_q[$past(unit_access_sel)])
    else $error("access to gated unit not faulted");

  clocked_no_fault_a: assert property (
    unit_access_valid && unit_access_sel < UNIT_LIMIT &&
    unit_enable[unit_access_sel] |=>
    !unit_access_fault)
    else $error("access to clocked unit faulted");

  run_two_layout_a: assert property (
    full_write_s(RUN_TWO_OFF) |=>
      run_two_q == ($past(wdata_q) & 32'h0001201f))
    else $error("run gate two layout wrong");

  deep_one_layout_a: assert property (
    full_write_s(DEEP_ONE_OFF) |=>
      deep_one_q == ($past(wdata_q) & 32'h00001011))
    else $error("deep gate one layout wrong");

  sleep_two_layout_a: assert property (
    full_write_s(SLEEP_TWO_OFF) |=>
      sleep_two_q == ($past(wdata_q) & 32'h0001201f))
    else $error("sleep gate two layout wrong");

  unmapped_read_a: assert property (
    ar_take && !rd_hit |=> rvalid && rresp == RESP_SLVERR &&
      rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
`default_nettype wire

// >>> hdl/pcg_pkg.sv
package pcg_pkg;
  // Register byte offsets from the system control base
  localparam logic [31:0] SYSCTL_BASE     = 32'h400fe000;
  localparam logic [11:0] RUN_TWO_OFF     = 12'h108;
  localparam logic [11:0] SLEEP_TWO_OFF   = 12'h118;
  localparam logic [11:0] DEEP_TWO_OFF    = 12'h128;
  localparam logic [11:0] DEEP_ONE_OFF    = 12'h200;
  localparam logic [11:0] RUN_CFG_OFF     = 12'h204;
  localparam logic [11:0] IRQ_STAT_OFF    = 12'h208;
  localparam logic [11:0] IRQ_MASK_OFF    = 12'h20c;
  // Writable bits of each register, all others reserved
  localparam logic [31:0] GATE_TWO_MASK   = 32'h0001201f;
  localparam logic [31:0] GATE_ONE_MASK   = 32'h00001011;
  localparam logic [31:0] RUN_CFG_MASK    = 32'h00000001;
  localparam logic [31:0] IRQ_MASK_MASK   = 32'h000003ff;
  // Values after reset
  localparam logic [31:0] GATE_RESET      = 32'h00000000;
  localparam logic [31:0] CFG_RESET       = 32'h00000000;
  // Field positions in the group-two gate registers
  localparam int          USB_BIT         = 16;
  localparam int          DMA_BIT         = 13;
  localparam int          PORT_A_BIT      = 0;
  localparam int          PORT_E_BIT      = 4;
  // Field positions in the group-one gate register
  localparam int          TWO_WIRE_BIT    = 12;
  localparam int          SYNC_SERIAL_BIT = 4;
  localparam int          ASYNC_SERIAL_BIT = 0;
  // Automatic gating select in run clock configuration
  localparam int          AUTO_GATE_BIT   = 0;
  // Unit numbering on the gate, clock and access ports
  localparam int          UNIT_COUNT      = 10;
  localparam logic [3:0]  UNIT_LIMIT      = 4'ha;
  // Power modes
  localparam logic [1:0]  MODE_RUN        = 2'h0;
  localparam logic [1:0]  MODE_SLEEP      = 2'h1;
  localparam logic [1:0]  MODE_DEEP       = 2'h2;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// >>> hdl/pcg_clock_gate.sv
`timescale 1ns/100ps
`default_nettype none
// Latch-based clock gate cell for one unit
module pcg_clock_gate (
  input  wire logic clk_in,
  input  wire logic enable,
  output logic      clk_out
);
  logic en_latch;  // Enable held through the high phase

  // glitch-free gating
  // Enable only moves while the clock is low, so no pulse is cut short
  always_latch begin
    if (!clk_in) begin
      en_latch <= enable;
    end
  end

  // Gated clock, low whenever the unit is switched off
  assign clk_out = clk_in & en_latch;
endmodule
`default_nettype wire

// >>> verif/tb_peripheral_clock_gating.sv
`timescale 1ns/100ps
`default_nettype none
module tb_peripheral_clock_gating;
  import pcg_pkg::*;
  // Bench stimulus, all given a value at time zero
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  power_mode = MODE_RUN;
  logic [2:0]  run_group_one_gate = 3'h0, sleep_group_one_gate = 3'h0;
  logic        unit_access_valid = 1'b0;
  logic [3:0]  unit_access_sel = 4'h0;
  // Design outputs
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        unit_access_fault, irq;
  logic [9:0]  unit_enable, unit_clk;
  int          errors = 0;
  int          n_tests = 0;

  pcg_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .power_mode(power_mode),
    .run_group_one_gate(run_group_one_gate),
    .sleep_group_one_gate(sleep_group_one_gate),
    .unit_access_valid(unit_access_valid),
    .unit_access_sel(unit_access_sel),
    .unit_access_fault(unit_access_fault), .unit_enable(unit_enable),
    .unit_clk(unit_clk), .irq(irq));

  // 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end

  // Single compare point, four-state exact
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected unit enables from a group-two word and group-one bits
  function automatic logic [9:0] en_of(logic [31:0] r, logic [2:0] g);
    return {g, r[USB_BIT], r[DMA_BIT], r[PORT_E_BIT:PORT_A_BIT]};
  endfunction

  // Write: address and data offered together, each dropped when taken
  task automatic axi_write(logic [11:0] off, logic [31:0] d,
                           logic [3:0] s, logic [1:0] exp_resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= SYSCTL_BASE | {20'h0, off};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
    bready <= 1'b0;
  endtask

  // Read one word and compare data and response
  task automatic axi_read(logic [11:0] off, logic [31:0] exp,
                          logic [1:0] exp_resp);
    araddr  <= SYSCTL_BASE | {20'h0, off};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    check("rdata", rdata, exp);
    check("rresp", {30'h0, rresp}, {30'h0, exp_resp});
    rready <= 1'b0;
  endtask

  // Enables settle one cycle after a write or mode change; allow three
  task automatic check_enables(logic [9:0] exp);
    repeat (3) @(posedge aclk);
    #2;
    check("unit_enable", {22'h0, unit_enable}, {22'h0, exp});
    check("unit_clk high", {22'h0, unit_clk}, {22'h0, exp});
    @(negedge aclk);
    #2;
    check("unit_clk low", {22'h0, unit_clk}, 32'h0);
    // Back on the rising edge so later stimulus stays edge aligned
    @(posedge aclk);
  endtask

  // One access to a unit, fault judged one cycle after the access
  task automatic access(logic [3:0] sel, logic exp_fault);
    @(posedge aclk);
    unit_access_valid <= 1'b1;
    unit_access_sel   <= sel;
    @(posedge aclk);
    unit_access_valid <= 1'b0;
    // Fault launched at the previous edge is sampled at this one
    @(posedge aclk);
    check("fault", {31'h0, unit_access_fault}, {31'h0, exp_fault});
  endtask

  task automatic test_reset_values;
    check("awready", {31'h0, awready}, 32'h1);
    check("wready", {31'h0, wready}, 32'h1);
    check("arready", {31'h0, arready}, 32'h1);
    axi_read(RUN_TWO_OFF, GATE_RESET, RESP_OKAY);
    axi_read(SLEEP_TWO_OFF, GATE_RESET, RESP_OKAY);
    axi_read(DEEP_TWO_OFF, GATE_RESET, RESP_OKAY);
    axi_read(DEEP_ONE_OFF, GATE_RESET, RESP_OKAY);
    axi_read(RUN_CFG_OFF, CFG_RESET, RESP_OKAY);
    check_enables(10'h0);
  endtask

  // Every writable bit set, reserved bits must stay zero
  task automatic test_run_fields;
    axi_write(RUN_TWO_OFF, 32'hffffffff, 4'hf, RESP_OKAY);
    axi_read(RUN_TWO_OFF, GATE_TWO_MASK, RESP_OKAY);
    run_group_one_gate <= 3'h7;
    check_enables(en_of(GATE_TWO_MASK, 3'h7));
    // Only the low byte lane cleared, so ports go off, usb and dma stay
    axi_write(RUN_TWO_OFF, 32'h0, 4'h1, RESP_OKAY);
    axi_read(RUN_TWO_OFF, 32'h00012000, RESP_OKAY);
    axi_write(SLEEP_TWO_OFF, 32'hffffffff, 4'hf, RESP_OKAY);
    axi_read(SLEEP_TWO_OFF, GATE_TWO_MASK, RESP_OKAY);
    axi_write(DEEP_ONE_OFF, 32'hffffffff, 4'hf, RESP_OKAY);
    axi_read(DEEP_ONE_OFF, GATE_ONE_MASK, RESP_OKAY);
    axi_write(12'h300, 32'h1, 4'hf, RESP_SLVERR);
    axi_read(12'h300, 32'h0, RESP_SLVERR);
  endtask

  // Gated unit faults, status latches, mask drives irq, read clears
  task automatic test_fault;
    axi_write(IRQ_MASK_OFF, 32'h4, 4'hf, RESP_OKAY);
    access(4'h5, 1'b0);
    access(4'h2, 1'b1);
    check("irq set", {31'h0, irq}, 32'h1);
    axi_read(IRQ_STAT_OFF, 32'h4, RESP_OKAY);
    check("irq clear", {31'h0, irq}, 32'h0);
    axi_read(IRQ_STAT_OFF, 32'h0, RESP_OKAY);
    // Fault on a masked bit still latches, irq stays low
    access(4'hc, 1'b0);
    access(4'h3, 1'b1);
    check("irq masked", {31'h0, irq}, 32'h0);
    axi_read(IRQ_STAT_OFF, 32'h8, RESP_OKAY);
  endtask

  // Register choice per power mode, with and without automatic gating
  task automatic test_modes;
    // Units set up before any use of them; reserved bits written back 0
    axi_write(RUN_TWO_OFF, 32'h10, 4'hf, RESP_OKAY);
    axi_write(SLEEP_TWO_OFF, 32'h1, 4'hf, RESP_OKAY);
    axi_write(DEEP_TWO_OFF, 32'h2000, 4'hf, RESP_OKAY);
    axi_write(DEEP_ONE_OFF, 32'h1011, 4'hf, RESP_OKAY);
    axi_write(RUN_CFG_OFF, 32'h0, 4'hf, RESP_OKAY);
    run_group_one_gate   <= 3'h1;
    sleep_group_one_gate <= 3'h2;
    power_mode <= MODE_SLEEP;
    check_enables(en_of(32'h10, 3'h1));
    power_mode <= MODE_DEEP;
    check_enables(en_of(32'h10, 3'h1));
    axi_write(RUN_CFG_OFF, 32'hffffffff, 4'hf, RESP_OKAY);
    axi_read(RUN_CFG_OFF, RUN_CFG_MASK, RESP_OKAY);
    check_enables(en_of(32'h2000, 3'h7));
    power_mode <= MODE_SLEEP;
    check_enables(en_of(32'h1, 3'h2));
    access(4'h4, 1'b1);
    access(4'h0, 1'b0);
    power_mode <= MODE_RUN;
    check_enables(en_of(32'h10, 3'h1));
  endtask

  // Single closing point for normal end and for the watchdog
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly 125 cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    give_verdict();
  end

  // Main sequence: reset held ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset_values();
    test_run_fields();
    // Only the dma unit left clocked for the fault scenario
    axi_write(RUN_TWO_OFF, 32'h2000, 4'hf, RESP_OKAY);
    run_group_one_gate <= 3'h0;
    test_fault();
    test_modes();
    give_verdict();
  end
endmodule
`default_nettype wire
